// ### logic/unbr_receiver.sv
/*
  Nine-bit address receiver top: register port, 16x data recovery,
  shift register, address filter, two-character store, flags.
  Assumes the receive line is synchronous to sys_clk and the register
  master keeps to one-cycle strobes.
*/
`timescale 1ns/1ps
module unbr_receiver
  import unbr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic serialReceivePin,
  output logic receivePendingFlag,
  output logic receiveInterrupt
);
  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {UNBR_IDLE, UNBR_START, UNBR_DATA, UNBR_STOP}
    unbr_state_t;

  logic [7:0] rxCtrl, next_rxCtrl;
  logic [7:0] baudLow, next_baudLow;
  logic [7:0] baudHigh, next_baudHigh;
  logic [7:0] txCtrl, next_txCtrl;
  logic [7:0] baudCtrl, next_baudCtrl;
  logic [7:0] intCtrl, next_intCtrl;
  logic [7:0] intEnable, next_intEnable;
  logic [7:0] next_regReadData;
  logic overrun, next_overrun;

  logic portEnable, nineBit, contEnable, addrDetect, syncMode;
  logic receiveActive, sampleTick;
  logic [9:0] headData;
  logic notEmpty, full, push, pop;
  logic [9:0] pushData;

  assign portEnable = rxCtrl[RS_PORT_EN];
  assign nineBit = rxCtrl[RS_NINE];
  assign contEnable = rxCtrl[RS_CONT];
  assign addrDetect = rxCtrl[RS_ADDR];
  assign syncMode = txCtrl[TS_SYNC];
  assign receiveActive = portEnable && contEnable && !syncMode;

  function automatic logic isAccess(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] r);
    return a == r;
  endfunction

  // Data register read advances the store; the ninth bit must be
  // fetched first from the status register
  assign pop = regRead && isAccess(regAddr, REG_RX_DATA);

  always_comb begin
    next_rxCtrl = rxCtrl;
    next_baudLow = baudLow;
    next_baudHigh = baudHigh;
    next_txCtrl = txCtrl;
    next_baudCtrl = baudCtrl;
    next_intCtrl = intCtrl;
    next_intEnable = intEnable;
    next_overrun = overrun;
    if (regWrite) begin
      case (regAddr)
        REG_RX_STATUS: next_rxCtrl = regWriteData;
        REG_BAUD_LOW: next_baudLow = regWriteData;
        REG_BAUD_HIGH: next_baudHigh = regWriteData;
        REG_TX_STATUS: next_txCtrl = regWriteData;
        REG_BAUD_CTRL: next_baudCtrl = regWriteData;
        REG_INT_CTRL: next_intCtrl = regWriteData;
        REG_INT_ENABLE: next_intEnable = regWriteData;
        default: next_rxCtrl = rxCtrl;
      endcase
    end
    // Completed third character sets overrun; set beats the clear
    if (!contEnable || !portEnable) begin
      next_overrun = 1'b0;
    end
    if (push && full) begin
      next_overrun = 1'b1;
    end
    next_regReadData = 8'h00;
    if (regRead) begin
      case (regAddr)
        REG_RX_STATUS: begin
          next_regReadData = {rxCtrl[7:3], headData[9] & notEmpty,
                              overrun, headData[8]};
        end
        REG_RX_DATA: next_regReadData = headData[7:0];
        REG_BAUD_LOW: next_regReadData = baudLow;
        REG_BAUD_HIGH: next_regReadData = baudHigh;
        REG_TX_STATUS: next_regReadData = txCtrl | TS_IDLE_VAL;
        REG_BAUD_CTRL: next_regReadData = baudCtrl;
        REG_INT_CTRL: next_regReadData = intCtrl;
        REG_INT_ENABLE: next_regReadData = intEnable;
        default: next_regReadData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxCtrl <= CTRL_RESET;
      baudLow <= CTRL_RESET;
      baudHigh <= CTRL_RESET;
      txCtrl <= CTRL_RESET;
      baudCtrl <= CTRL_RESET;
      intCtrl <= CTRL_RESET;
      intEnable <= CTRL_RESET;
      overrun <= 1'b0;
      regReadData <= 8'h00;
    end else begin
      rxCtrl <= next_rxCtrl;
      baudLow <= next_baudLow;
      baudHigh <= next_baudHigh;
      txCtrl <= next_txCtrl;
      baudCtrl <= next_baudCtrl;
      intCtrl <= next_intCtrl;
      intEnable <= next_intEnable;
      overrun <= next_overrun;
      regReadData <= next_regReadData;
    end
  end

  // ----------------------------------------------------------------
  // Baud divider
  // ----------------------------------------------------------------
  unbr_baud u_baud (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .enable(receiveActive),
    .divisor({baudHigh, baudLow}),
    .highRate(txCtrl[TS_HIGH]),
    .wideDivisor(baudCtrl[BC_WIDE]),
    .sampleTick(sampleTick)
  );

  // ----------------------------------------------------------------
  // Data recovery
  // ----------------------------------------------------------------
  unbr_state_t state, next_state;
  logic [3:0] tick, next_tick;
  logic [3:0] bitCount, next_bitCount;
  logic [8:0] shiftReg, next_shiftReg;
  logic [2:0] votes, next_votes;
  logic lineBit;

  function automatic logic majority(input logic [2:0] v);
    return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction

  assign lineBit = majority(votes);

  always_comb begin
    next_state = state;
    next_tick = tick;
    next_bitCount = bitCount;
    next_shiftReg = shiftReg;
    next_votes = votes;
    push = 1'b0;
    pushData = {1'b0, shiftReg};
    if (!receiveActive || overrun) begin
      // Overrun blocks reception until cleared
      next_state = UNBR_IDLE;
    end else if (sampleTick) begin
      next_tick = tick + 1'b1;
      if (tick == VOTE_A) next_votes[0] = serialReceivePin;
      if (tick == VOTE_B) next_votes[1] = serialReceivePin;
      if (tick == VOTE_C) next_votes[2] = serialReceivePin;
      case (state)
        UNBR_IDLE: begin
          next_tick = '0;
          if (!serialReceivePin) next_state = UNBR_START;
        end
        UNBR_START: begin
          if (tick == HALF_BIT && serialReceivePin) begin
            // Glitch shorter than half a bit: back to hunting
            next_state = UNBR_IDLE;
          end else if (tick == LAST_TICK) begin
            // Tick count wraps at the start of bit 0, so the three
            // votes land mid-bit rather than on the bit edge
            next_bitCount = '0;
            next_state = UNBR_DATA;
          end
        end
        UNBR_DATA: begin
          if (tick == LAST_TICK) begin
            // Shift LSB first; eight-bit mode leaves bit nine zero
            next_shiftReg = nineBit ? {lineBit, shiftReg[8:1]}
                                    : {1'b0, lineBit, shiftReg[7:1]};
            next_bitCount = bitCount + 1'b1;
            if (bitCount == (nineBit ? NINE_BITS : EIGHT_BITS)
                - 1'b1) begin
              next_state = UNBR_STOP;
            end
          end
        end
        UNBR_STOP: begin
          if (tick == LAST_TICK) begin
            next_state = UNBR_IDLE;
            pushData = {!lineBit, shiftReg};
            // Address mode drops characters with ninth bit zero and
            // touches nothing else
            push = !addrDetect || shiftReg[8];
          end
        end
        default: next_state = UNBR_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= UNBR_IDLE;
      tick <= '0;
      bitCount <= '0;
      shiftReg <= '0;
      votes <= '0;
    end else begin
      state <= next_state;
      tick <= next_tick;
      bitCount <= next_bitCount;
      shiftReg <= next_shiftReg;
      votes <= next_votes;
    end
  end

  // ----------------------------------------------------------------
  // Character store and pending flag
  // ----------------------------------------------------------------
  // A full store takes no push; the overrun flag records the loss
  unbr_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .flush(!portEnable),
    .push(push && !full),
    .pushData(pushData),
    .pop(pop),
    .headData(headData),
    .notEmpty(notEmpty),
    .full(full)
  );

  assign receivePendingFlag = notEmpty && portEnable;
  assign receiveInterrupt = receivePendingFlag && intEnable[IE_RX]
    && intCtrl[IC_PERIPH] && intCtrl[IC_GLOBAL];
endmodule // unbr_receiver

// ### inc/unbr_pkg.sv
/*
  Package for the nine-bit address receiver: register indices, bit
  positions, reset values and timing constants.
  Assumes a register port with one-cycle strobes and 8-bit data.
*/
package unbr_pkg;
  // ----------------------------------------------------------------
  // Register indices (word address)
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_RX_STATUS = 3'h0;
  localparam logic [2:0] REG_RX_DATA = 3'h1;
  localparam logic [2:0] REG_BAUD_LOW = 3'h2;
  localparam logic [2:0] REG_BAUD_HIGH = 3'h3;
  localparam logic [2:0] REG_TX_STATUS = 3'h4;
  localparam logic [2:0] REG_BAUD_CTRL = 3'h5;
  localparam logic [2:0] REG_INT_CTRL = 3'h6;
  localparam logic [2:0] REG_INT_ENABLE = 3'h7;
  localparam int ADDR_W = 3;
  // ----------------------------------------------------------------
  // Bit positions
  // ----------------------------------------------------------------
  localparam int RS_PORT_EN = 7;
  localparam int RS_NINE = 6;
  localparam int RS_CONT = 4;
  localparam int RS_ADDR = 3;
  localparam int RS_FRAME = 2;
  localparam int RS_OVER = 1;
  localparam int RS_NINTH = 0;
  localparam int TS_SYNC = 4;
  localparam int TS_HIGH = 2;
  localparam int TS_IDLE = 1;
  localparam int BC_IDLE = 6;
  localparam int BC_WIDE = 3;
  localparam int IC_GLOBAL = 7;
  localparam int IC_PERIPH = 6;
  localparam int IE_RX = 5;
  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] TS_IDLE_VAL = 8'h02;
  localparam int FIFO_DEPTH = 2;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] HALF_BIT = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam logic [3:0] VOTE_A = 4'h6;
  localparam logic [3:0] VOTE_B = 4'h7;
  localparam logic [3:0] VOTE_C = 4'h8;
  localparam logic [3:0] EIGHT_BITS = 4'h8;
  localparam logic [3:0] NINE_BITS = 4'h9;
  localparam logic [1:0] PRESCALE_LOW = 2'h3;
  localparam logic [1:0] PRESCALE_HIGH = 2'h0;
endpackage

// ### logic/unbr_fifo.sv
/*
  Two-entry character store: nine data bits plus a framing flag per
  entry, read data from a register.
  Assumes the writer never pushes while full.
*/
`timescale 1ns/1ps
module unbr_fifo
  import unbr_pkg::*;
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  input wire logic pop,
  output logic [WIDTH-1:0] headData,
  output logic notEmpty,
  output logic full
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];
  logic [$clog2(DEPTH):0] count;
  logic [$clog2(DEPTH):0] next_count;
  logic [WIDTH-1:0] next_headData;

  assign notEmpty = (count != '0);
  assign full = (count == ($clog2(DEPTH)+1)'(DEPTH));

  always_comb begin
    next_count = count;
    if (flush) begin
      next_count = '0;
    end else if (push && !(pop && notEmpty)) begin
      next_count = count + 1'b1;
    end else if (pop && !push && notEmpty) begin
      next_count = count - 1'b1;
    end
    // Head is the oldest entry; after a pop the next one moves up
    next_headData = mem[0];
    if (pop && notEmpty) begin
      next_headData = (count > 1) ? mem[1] : pushData;
    end else if (push && !notEmpty) begin
      next_headData = pushData;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      headData <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      count <= next_count;
      headData <= next_headData;
      if (pop && notEmpty) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          mem[i] <= mem[i+1];
        end
      end
      if (push) begin
        if (pop && notEmpty) begin
          mem[count-1] <= pushData;
        end else begin
          mem[count[$clog2(DEPTH)-1:0]] <= pushData;
        end
      end
    end
  end
endmodule // unbr_fifo

// ### logic/unbr_baud.sv
/*
  Baud divider: makes a one-cycle tick at sixteen times the bit rate.
  Assumes divisor and select bits change only while idle.
*/
`timescale 1ns/1ps
module unbr_baud
  import unbr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic [15:0] divisor,
  input wire logic highRate,
  input wire logic wideDivisor,
  output logic sampleTick
);
  // ----------------------------------------------------------------
  // Divisor plus prescale
  // ----------------------------------------------------------------
  logic [15:0] count;
  logic [15:0] next_count;
  logic [1:0] pre;
  logic [1:0] next_pre;
  logic [15:0] limit;
  logic [1:0] preLimit;
  logic next_tick;

  // Narrow divisor uses only the low byte
  assign limit = wideDivisor ? divisor : {8'h00, divisor[7:0]};
  // Low rate spreads each oversample over four divider periods
  assign preLimit = highRate ? PRESCALE_HIGH : PRESCALE_LOW;

  always_comb begin
    next_count = count - 1'b1;
    next_pre = pre;
    next_tick = 1'b0;
    if (!enable) begin
      next_count = limit;
      next_pre = preLimit;
    end else if (count == '0) begin
      next_count = limit;
      if (pre == '0) begin
        next_pre = preLimit;
        next_tick = 1'b1;
      end else begin
        next_pre = pre - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      pre <= '0;
      sampleTick <= 1'b0;
    end else begin
      count <= next_count;
      pre <= next_pre;
      sampleTick <= next_tick;
    end
  end
endmodule // unbr_baud

// ### verif/unbr_receiver_chk.sv
/*
  Port checker for the nine-bit address receiver.
  Assumes one clock domain and single-cycle register strobes.
*/
`timescale 1ns/1ps
module unbr_receiver_chk
  import unbr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire logic serialReceivePin,
  input wire logic receivePendingFlag,
  input wire logic receiveInterrupt
);
  // ------------------------------------------------------------
  // Shadow copies of the receive, interrupt and low divisor controls
  // ------------------------------------------------------------
  logic [7:0] rxCtl, intCtl, intEn, divLow;
  logic [7:0] next_rxCtl, next_intCtl, next_intEn, next_divLow;
  logic dataRead;
  logic statRead;
  assign dataRead = regRead && regAddr == REG_RX_DATA;
  assign statRead = regRead && regAddr == REG_RX_STATUS;

  always_comb begin
    next_rxCtl = rxCtl;
    next_intCtl = intCtl;
    next_intEn = intEn;
    next_divLow = divLow;
    if (regWrite) begin
      case (regAddr)
        REG_RX_STATUS: next_rxCtl = regWriteData;
        REG_INT_CTRL: next_intCtl = regWriteData;
        REG_INT_ENABLE: next_intEn = regWriteData;
        REG_BAUD_LOW: next_divLow = regWriteData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxCtl <= 8'h00;
      intCtl <= 8'h00;
      intEn <= 8'h00;
      divLow <= 8'h00;
    end else begin
      rxCtl <= next_rxCtl;
      intCtl <= next_intCtl;
      intEn <= next_intEn;
      divLow <= next_divLow;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_idle_read_zero: assert property (!regRead
    |=> regReadData == 8'h00)
    else $error("read data not zero outside a read");
  a_irq_gating: assert property (receiveInterrupt == (
    receivePendingFlag && intEn[IE_RX] && intCtl[IC_GLOBAL]
    && intCtl[IC_PERIPH]))
    else $error("interrupt does not follow pending and enables");
  a_ctl_readback: assert property (statRead |=>
    regReadData[7:6] == rxCtl[7:6] && regReadData[4:3] == rxCtl[4:3])
    else $error("status control bits read back wrong");
  a_pending_needs_port: assert property (!rxCtl[RS_PORT_EN]
    |-> !receivePendingFlag)
    else $error("pending while port disabled");
  a_pending_needs_rx: assert property ($rose(receivePendingFlag)
    |-> $past(rxCtl[RS_CONT]))
    else $error("character taken while reception off");
  a_pending_holds: assert property (receivePendingFlag && !dataRead
    && !(regWrite && regAddr == REG_RX_STATUS) |=> receivePendingFlag)
    else $error("pending dropped without a data read");
  a_div_readback: assert property (regRead && regAddr == REG_BAUD_LOW
    |=> regReadData == divLow)
    else $error("divisor low read back wrong");
  a_addr_ninth: assert property (statRead && rxCtl[RS_ADDR]
    && receivePendingFlag |=> regReadData[RS_NINTH])
    else $error("ninth bit clear in address mode");
endmodule // unbr_receiver_chk

bind unbr_receiver unbr_receiver_chk chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .regAddr(regAddr), .regWriteData(regWriteData),
  .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
  .serialReceivePin(serialReceivePin),
  .receivePendingFlag(receivePendingFlag),
  .receiveInterrupt(receiveInterrupt));

// ### verif/unbr_tx_model.sv
/*
  Remote asynchronous transmitter on the shared serial line.
  Assumes the receiver samples the line on sys_clk.
*/
`timescale 1ns/1ps
module unbr_tx_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic sys_clk,
  output logic serialLine
);
  int bitClks = BIT_CLKS;
  initial serialLine = 1'b1;

  task automatic hold(input logic lvl, input int n);
    serialLine <= lvl;
    repeat (n) @(posedge sys_clk);
  endtask

  // Start, data LSB first, stop, then one idle bit so the receiver
  // finishes its stop bit before the next start edge
  task automatic send(input logic [8:0] d, input logic nine,
                      input logic stopLvl);
    hold(1'b0, bitClks);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      hold(d[i], bitClks);
    end
    hold(stopLvl, bitClks);
    hold(1'b1, bitClks);
  endtask

  // Short low pulse that must not pass the half-bit start check
  task automatic glitch();
    hold(1'b0, 4);
    hold(1'b1, 2 * bitClks);
  endtask
endmodule // unbr_tx_model

// ### verif/unbr_receiver_bench.sv
/*
  Self-checking bench for the nine-bit address receiver.
  Assumes the checker is bound and the far end model drives the line.
*/
`timescale 1ns/1ps
module unbr_receiver_bench
  import unbr_pkg::*;
;
  logic sys_clk, reset_n, regWrite, regRead, serialReceivePin;
  logic receivePendingFlag, receiveInterrupt;
  logic [ADDR_W-1:0] regAddr;
  logic [7:0] regWriteData, regReadData;
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  unbr_receiver dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
    .regRead(regRead), .regReadData(regReadData),
    .serialReceivePin(serialReceivePin),
    .receivePendingFlag(receivePendingFlag),
    .receiveInterrupt(receiveInterrupt));
  unbr_tx_model farEnd (.sys_clk(sys_clk), .serialLine(serialReceivePin));

  // ------------------------------------------------------------
  // Clock, timeout and report
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // Register port and compare tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  task automatic expect_reg(input logic [ADDR_W-1:0] a,
                            input logic [7:0] exp);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 check(regReadData, exp);
  endtask

  task automatic flag_is(input logic e);
    check({7'h00, receivePendingFlag}, {7'h00, e});
  endtask

  // Wait past the push at the end of the stop bit
  task automatic send(input logic [8:0] d, input logic nine,
                      input logic stopLvl);
    farEnd.send(d, nine, stopLvl);
    repeat (4) @(posedge sys_clk);
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin : main
    logic [2:0] k;
    reset_n = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 3'h0;
    regWriteData = 8'h00;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    expect_reg(REG_RX_STATUS, CTRL_RESET);
    expect_reg(REG_TX_STATUS, TS_IDLE_VAL);
    // Divisor zero at high rate gives a 16-clock bit
    wr(REG_TX_STATUS, 8'h04);
    wr(REG_RX_STATUS, 8'hc0);
    send(9'h1a5, 1'b1, 1'b1);
    flag_is(1'b0);
    wr(REG_RX_STATUS, 8'hd0);
    send(9'h1a5, 1'b1, 1'b1);
    flag_is(1'b1);
    expect_reg(REG_RX_STATUS, 8'hd1);
    expect_reg(REG_RX_DATA, 8'ha5);
    flag_is(1'b0);
    send(9'h033, 1'b1, 1'b0);
    expect_reg(REG_RX_STATUS, 8'hd4);
    expect_reg(REG_RX_DATA, 8'h33);
    send(9'h0f0, 1'b1, 1'b1);
    expect_reg(REG_RX_STATUS, 8'hd0);
    expect_reg(REG_RX_DATA, 8'hf0);
    $display("test basic done");
    wr(REG_RX_STATUS, 8'hd8);
    send(9'h1c3, 1'b1, 1'b1);
    send(9'h055, 1'b1, 1'b0);
    expect_reg(REG_RX_STATUS, 8'hd9);
    expect_reg(REG_RX_DATA, 8'hc3);
    flag_is(1'b0);
    wr(REG_RX_STATUS, 8'hd0);
    send(9'h044, 1'b1, 1'b1);
    expect_reg(REG_RX_STATUS, 8'hd0);
    expect_reg(REG_RX_DATA, 8'h44);
    wr(REG_RX_STATUS, 8'hd8);
    send(9'h0bb, 1'b1, 1'b1);
    flag_is(1'b0);
    send(9'h1bb, 1'b1, 1'b1);
    expect_reg(REG_RX_STATUS, 8'hd9);
    expect_reg(REG_RX_DATA, 8'hbb);
    wr(REG_RX_STATUS, 8'hd0);
    $display("test address done");
    send(9'h066, 1'b1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      wr(REG_INT_ENABLE, {2'b00, k[0], 5'h00});
      wr(REG_INT_CTRL, {k[2], k[1], 6'h00});
      #1 check({7'h00, receiveInterrupt}, {7'h00, &k});
    end
    expect_reg(REG_RX_DATA, 8'h66);
    check({7'h00, receiveInterrupt}, 8'h00);
    $display("test interrupt done");
    send(9'h011, 1'b1, 1'b1);
    send(9'h022, 1'b1, 1'b1);
    send(9'h033, 1'b1, 1'b1);
    expect_reg(REG_RX_STATUS, 8'hd2);
    send(9'h077, 1'b1, 1'b1);
    expect_reg(REG_RX_DATA, 8'h11);
    expect_reg(REG_RX_DATA, 8'h22);
    flag_is(1'b0);
    wr(REG_RX_STATUS, 8'hc0);
    expect_reg(REG_RX_STATUS, 8'hc0);
    wr(REG_RX_STATUS, 8'hd0);
    send(9'h088, 1'b1, 1'b1);
    expect_reg(REG_RX_DATA, 8'h88);
    $display("test overrun done");
    farEnd.glitch();
    flag_is(1'b0);
    send(9'h1e7, 1'b1, 1'b1);
    expect_reg(REG_RX_STATUS, 8'hd1);
    expect_reg(REG_RX_DATA, 8'he7);
    $display("test glitch done");
    // Wide divisor 1, low rate: (1+1)*4 clocks a tick, 128 a bit
    wr(REG_BAUD_LOW, 8'h01);
    expect_reg(REG_BAUD_LOW, 8'h01);
    wr(REG_BAUD_CTRL, 8'h08);
    wr(REG_TX_STATUS, 8'h00);
    expect_reg(REG_TX_STATUS, TS_IDLE_VAL);
    wr(REG_RX_STATUS, 8'h90);
    farEnd.bitClks = 128;
    send(9'h05a, 1'b0, 1'b1);
    expect_reg(REG_RX_STATUS, 8'h90);
    expect_reg(REG_RX_DATA, 8'h5a);
    $display("test rate done");
    close_out();
  end
endmodule // unbr_receiver_bench
